// *** sdac_defines.vh ***
`ifndef SDAC_DEFINES_VH
`define SDAC_DEFINES_VH

// ****************************************
// Clock and timing
// ****************************************
`define SDAC_CLK_MHZ 100
`define SDAC_CE_HOLD_NS 1400
`define SDAC_CE_HOLD_CYC ((`SDAC_CE_HOLD_NS * `SDAC_CLK_MHZ + 999) / 1000)
`define SDAC_WIN0_US 192
`define SDAC_WIN1_US 384
`define SDAC_WIN0_CYC (`SDAC_WIN0_US * `SDAC_CLK_MHZ)
`define SDAC_WIN1_CYC (`SDAC_WIN1_US * `SDAC_CLK_MHZ)
`define SDAC_PON_DISCARD 9'd80
`define SDAC_LATENCY_IRQS 2'd3
`define SDAC_DEV_RD_WAIT 3'd4

// ****************************************
// Controller registers on APB
// ****************************************
`define SDAC_REG_CTRL 8'h00
`define SDAC_REG_DEVWR 8'h04
`define SDAC_REG_STATUS 8'h08
`define SDAC_REG_ISTAT 8'h0c
`define SDAC_REG_IMASK 8'h10
`define SDAC_REG_RES_BASE 8'h20
`define SDAC_REG_RES_LAST 8'h2c
`define SDAC_CTRL_RESET 32'h0000_0000
`define SDAC_CTRL_PON 0
`define SDAC_CTRL_RATE 1
`define SDAC_CTRL_CE_LSB 2
`define SDAC_CTRL_EXTRA_LSB 8
`define SDAC_EV_DONE 0
`define SDAC_EV_MISS 1
`define SDAC_EV_REFUSE 2
`define SDAC_EV_SETTLED 3

// ****************************************
// Converter register map on the device port
// ****************************************
`define SDAC_DEV_MODE 8'h00
`define SDAC_DEV_GAIN0 8'h01
`define SDAC_DEV_GAIN1 8'h02
`define SDAC_DEV_HPF 8'h03
`define SDAC_DEV_ICR 8'h04
`define SDAC_DEV_CLR 8'h05
`define SDAC_DEV_PHASE0 8'h06
`define SDAC_DEV_PHASE3 8'h09
`define SDAC_DEV_RES_BASE 8'h10
`define SDAC_MODE_RATE 6
`define SDAC_MODE_PON 7

`endif

// *** sdac_result_mem.v ***
`timescale 1ns/1ns
module sdac_result_mem (
	// Clock and reset
	input wire core_clk,
	input wire rst_b,
	// Write port
	input wire wrEn,
	input wire [1:0] wrAddr,
	input wire [23:0] wrData,
	// Read port
	input wire [1:0] rdAddr,
	output reg [23:0] rdData
);

	reg [23:0] mem [0:3];

	always @(posedge core_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	// Registered read keeps the bus path short
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData <= 24'h000000;
		end else begin
			rdData <= mem[rdAddr];
		end
	end

endmodule

// *** sdac_ctrl.v ***
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "sdac_defines.vh"
// Notes on behaviour
// - Result bytes are read only after a conversion-end interrupt.
// - Reads finish within 192 us, or 384 us with fast rate clear.
// - Low, middle and high byte reads share that same window.
// - After power-on the first 80 conversions are thrown away.
// - After a stop and restart one conversion is thrown away.
// - Conversion enable stays low at least 1.4 us before re-enable.
// - Sample-rate bit changes only while converter power is off.
// - Gain, filter, channel select and phase written only while stopped.
// - Results are read only while conversion is enabled.
// - Power is cleared before software enters stop mode.
// - Interrupt control rewrite waits three conversion interrupts.
// - Level zero-cross interrupt stays until cleared by the clear register.
// - Filter settling varies; extra conversions may be discarded on enable.
module sdac_ctrl #(
	parameter [15:0] WIN0_CYC = `SDAC_WIN0_CYC,
	parameter [15:0] WIN1_CYC = `SDAC_WIN1_CYC
) (
	// Clock and reset
	input wire core_clk,
	input wire rst_b,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg irqOut,
	// Converter register port
	output reg [7:0] devAddr,
	output reg [7:0] devWdata,
	output reg devWr,
	output reg devRd,
	input wire [7:0] devRdata,
	input wire conversionEndIrq
);

	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_RWAIT = 2'b10;

	// ****************************************
	// Input synchronisers
	// ****************************************
	reg [7:0] rdS1_q, rdS2_q;
	reg irqS1_q, irqS2_q, irqS3_q;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdS1_q <= 8'h00;
			rdS2_q <= 8'h00;
			irqS1_q <= 1'b0;
			irqS2_q <= 1'b0;
			irqS3_q <= 1'b0;
		end else begin
			rdS1_q <= devRdata;
			rdS2_q <= rdS1_q;
			irqS1_q <= conversionEndIrq;
			irqS2_q <= irqS1_q;
			irqS3_q <= irqS2_q;
		end
	end
	wire irqEv = irqS2_q & ~irqS3_q;

	// ****************************************
	// State
	// ****************************************
	reg [1:0] state_q;
	reg [31:0] ctrl_q;
	reg [15:0] devwr_q;
	reg devwrPend_q;
	reg [7:0] mode_q;
	reg [8:0] discard_q;
	reg [7:0] holdCnt_q;
	reg [15:0] winCnt_q;
	reg readPend_q;
	reg [1:0] rdChan_q;
	reg [1:0] rdByte_q;
	reg [2:0] waitCnt_q;
	reg [15:0] acc_q;
	reg [1:0] icrLat_q;
	reg [3:0] istat_q;
	reg [3:0] imask_q;
	reg memWr_q;
	reg [23:0] memData_q;
	wire [23:0] memRd;
	wire [1:0] clrLat0, clrLat1;
	reg [1:0] clrAcc;

	wire curPon = mode_q[`SDAC_MODE_PON];
	wire curRate = mode_q[`SDAC_MODE_RATE];
	wire [3:0] curCe = mode_q[3:0];
	wire ceOn = |curCe;
	wire tgtPon = ctrl_q[`SDAC_CTRL_PON];
	wire tgtRate = ctrl_q[`SDAC_CTRL_RATE];
	wire [3:0] tgtCe = tgtPon ? ctrl_q[`SDAC_CTRL_CE_LSB+3:`SDAC_CTRL_CE_LSB] : 4'h0;
	wire holdDone = (holdCnt_q >= `SDAC_CE_HOLD_CYC);
	wire [8:0] restartDiscard = {1'b0, ctrl_q[`SDAC_CTRL_EXTRA_LSB+7:`SDAC_CTRL_EXTRA_LSB]} + 9'd1;

	// ****************************************
	// Next action when idle
	// ****************************************
	reg actWr, actMode, actClrHold, actPon, actRestart, actRefuse, actDevwr;
	reg [7:0] actAddr, actData;
	reg [1:0] clrReq;
	always @* begin
		actWr = 1'b0;
		actMode = 1'b0;
		actClrHold = 1'b0;
		actPon = 1'b0;
		actRestart = 1'b0;
		actRefuse = 1'b0;
		actDevwr = 1'b0;
		actAddr = `SDAC_DEV_MODE;
		actData = 8'h00;
		clrAcc = 2'b00;
		clrReq = devwr_q[1:0];
		if (curPon && (!tgtPon || tgtRate != curRate)) begin
			actWr = 1'b1;
			actMode = 1'b1;
			actClrHold = 1'b1;
			actData = {1'b0, curRate, 6'h00};
		end else if (!curPon && tgtRate != curRate) begin
			actWr = 1'b1;
			actMode = 1'b1;
			actData = {1'b0, tgtRate, 6'h00};
		end else if (!curPon && tgtPon) begin
			actWr = 1'b1;
			actMode = 1'b1;
			actPon = 1'b1;
			actData = {1'b1, curRate, 6'h00};
		end else if (ceOn && curCe != tgtCe) begin
			actWr = 1'b1;
			actMode = 1'b1;
			actClrHold = 1'b1;
			actData = {1'b1, curRate, 6'h00};
		end else if (!ceOn && tgtCe != 4'h0 && holdDone) begin
			actWr = 1'b1;
			actMode = 1'b1;
			actRestart = 1'b1;
			actData = {1'b1, curRate, 2'b00, tgtCe};
		end else if (devwrPend_q) begin
			actDevwr = 1'b1;
			actAddr = devwr_q[15:8];
			actData = devwr_q[7:0];
			if (actAddr == `SDAC_DEV_MODE || actAddr >= `SDAC_DEV_RES_BASE) begin
				actRefuse = 1'b1;
			end else if (actAddr == `SDAC_DEV_CLR) begin
				// Bits still in their latency are dropped, not resent
				clrReq = devwr_q[1:0] & {(clrLat1 == 2'd0), (clrLat0 == 2'd0)};
				clrAcc = clrReq;
				actData = {devwr_q[7:2], clrReq};
				actWr = 1'b1;
			end else if (ceOn) begin
				actRefuse = 1'b1;
			end else if (actAddr == `SDAC_DEV_ICR && icrLat_q != 2'd0) begin
				actRefuse = 1'b1;
			end else begin
				// Output mode and unit channel select pass through
				actWr = 1'b1;
			end
		end
	end

	// ****************************************
	// Channel walk: next enabled channel above the current one
	// ****************************************
	reg [1:0] nextChan;
	reg nextFound;
	reg [1:0] firstChan;
	integer i;
	always @* begin
		nextChan = 2'd0;
		nextFound = 1'b0;
		firstChan = 2'd0;
		for (i = 3; i >= 0; i = i - 1) begin
			if (curCe[i]) begin
				firstChan = i[1:0];
				if (i > rdChan_q) begin
					nextChan = i[1:0];
					nextFound = 1'b1;
				end
			end
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	reg evDone, evMiss, evSettled;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			mode_q <= 8'h00;
			discard_q <= 9'd0;
			holdCnt_q <= 8'hff;
			winCnt_q <= 16'h0000;
			readPend_q <= 1'b0;
			rdChan_q <= 2'd0;
			rdByte_q <= 2'd0;
			waitCnt_q <= 3'd0;
			acc_q <= 16'h0000;
			icrLat_q <= 2'd0;
			devAddr <= 8'h00;
			devWdata <= 8'h00;
			devWr <= 1'b0;
			devRd <= 1'b0;
			memWr_q <= 1'b0;
			memData_q <= 24'h000000;
			evDone <= 1'b0;
			evMiss <= 1'b0;
			evSettled <= 1'b0;
		end else begin
			devWr <= 1'b0;
			devRd <= 1'b0;
			memWr_q <= 1'b0;
			evDone <= 1'b0;
			evMiss <= 1'b0;
			evSettled <= 1'b0;
			if (!ceOn && !holdDone) begin
				holdCnt_q <= holdCnt_q + 8'd1;
			end
			if (readPend_q && winCnt_q != 16'h0000) begin
				winCnt_q <= winCnt_q - 16'd1;
			end
			// Latency only advances on interrupts while converting
			if (irqEv && ceOn && icrLat_q != 2'd0) begin
				icrLat_q <= icrLat_q - 2'd1;
			end
			if (irqEv && ceOn) begin
				if (discard_q != 9'd0) begin
					discard_q <= discard_q - 9'd1;
					evSettled <= (discard_q == 9'd1);
				end else begin
					if (readPend_q) begin
						evMiss <= 1'b1;
					end
					// Each interrupt opens a fresh window for all bytes
					readPend_q <= 1'b1;
					winCnt_q <= curRate ? WIN1_CYC : WIN0_CYC;
					rdChan_q <= firstChan;
					rdByte_q <= 2'd0;
				end
			end else if (readPend_q && winCnt_q == 16'h0000) begin
				readPend_q <= 1'b0;
				evMiss <= 1'b1;
			end
			case (state_q)
				ST_IDLE: begin
					if (readPend_q && ceOn && !irqEv && winCnt_q != 16'h0000) begin
						devRd <= 1'b1;
						devAddr <= `SDAC_DEV_RES_BASE + {4'h0, rdChan_q, rdByte_q};
						waitCnt_q <= 3'd0;
						state_q <= ST_RWAIT;
					end else if (!readPend_q && actWr) begin
						devWr <= 1'b1;
						devAddr <= actAddr;
						devWdata <= actData;
						if (actMode) begin
							mode_q <= actData;
						end
						if (actClrHold) begin
							holdCnt_q <= 8'd0;
						end
						if (actPon) begin
							discard_q <= `SDAC_PON_DISCARD;
						end
						if (actRestart) begin
							discard_q <= (discard_q > restartDiscard) ? discard_q :
								restartDiscard;
						end
						if (actDevwr && actAddr == `SDAC_DEV_ICR) begin
							icrLat_q <= `SDAC_LATENCY_IRQS;
						end
					end
				end
				ST_RWAIT: begin
					waitCnt_q <= waitCnt_q + 3'd1;
					if (waitCnt_q == `SDAC_DEV_RD_WAIT) begin
						state_q <= ST_IDLE;
						if (rdByte_q == 2'd2) begin
							memWr_q <= 1'b1;
							memData_q <= {rdS2_q, acc_q};
							rdByte_q <= 2'd0;
							rdChan_q <= nextChan;
							if (!nextFound && !(irqEv && ceOn && discard_q == 9'd0)) begin
								readPend_q <= 1'b0;
								evDone <= 1'b1;
							end
						end else begin
							acc_q <= {rdS2_q, acc_q[15:8]};
							rdByte_q <= rdByte_q + 2'd1;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Zero-cross clear latency per unit
	// ****************************************
	reg [1:0] memChan_q;
	wire doClr = (state_q == ST_IDLE) && !readPend_q && actDevwr && actWr;
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : gClr
			reg [1:0] lat_q;
			always @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					lat_q <= 2'd0;
				end else if (doClr && clrAcc[g]) begin
					lat_q <= `SDAC_LATENCY_IRQS;
				end else if (irqEv && ceOn && lat_q != 2'd0) begin
					lat_q <= lat_q - 2'd1;
				end
			end
		end
	endgenerate
	assign clrLat0 = gClr[0].lat_q;
	assign clrLat1 = gClr[1].lat_q;

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			memChan_q <= 2'd0;
		end else if (state_q == ST_RWAIT && rdByte_q == 2'd2) begin
			memChan_q <= rdChan_q;
		end
	end

	sdac_result_mem uMem (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.wrEn(memWr_q),
		.wrAddr(memChan_q),
		.wrData(memData_q),
		.rdAddr(paddr[3:2]),
		.rdData(memRd)
	);

	// ****************************************
	// APB slave and interrupt
	// ****************************************
	wire apbDone = psel & penable & pready;
	wire wrHit = apbDone & pwrite;
	wire evRefuse = (state_q == ST_IDLE) && !readPend_q && actDevwr && actRefuse;
	wire devwrTake = (state_q == ST_IDLE) && !readPend_q && actDevwr;
	wire [3:0] events;
	wire [3:0] istatClr = (wrHit && paddr == `SDAC_REG_ISTAT) ? pwdata[3:0] : 4'h0;
	wire isRes = (paddr >= `SDAC_REG_RES_BASE) && (paddr <= `SDAC_REG_RES_LAST) &&
		(paddr[1:0] == 2'b00);
	wire [31:0] statusWord = {9'd0, devwrPend_q, clrLat1, clrLat0, icrLat_q,
		discard_q[7:0], (curPon && ceOn && discard_q == 9'd0),
		(readPend_q | devwrPend_q), curCe, curRate, curPon};
	assign events[`SDAC_EV_DONE] = evDone;
	assign events[`SDAC_EV_MISS] = evMiss;
	assign events[`SDAC_EV_REFUSE] = evRefuse | (wrHit && paddr == `SDAC_REG_DEVWR && devwrPend_q);
	assign events[`SDAC_EV_SETTLED] = evSettled;

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irqOut <= 1'b0;
			ctrl_q <= `SDAC_CTRL_RESET;
			devwr_q <= 16'h0000;
			devwrPend_q <= 1'b0;
			istat_q <= 4'h0;
			imask_q <= 4'h0;
		end else begin
			pready <= psel & penable & ~pready;
			// Error stands only beside its ready pulse, never into the next transfer
			pslverr <= 1'b0;
			if (psel && penable && !pready) begin
				if (paddr == `SDAC_REG_CTRL) begin
					prdata <= ctrl_q;
				end else if (paddr == `SDAC_REG_DEVWR) begin
					prdata <= {16'h0000, devwr_q};
				end else if (paddr == `SDAC_REG_STATUS) begin
					prdata <= statusWord;
				end else if (paddr == `SDAC_REG_ISTAT) begin
					prdata <= {28'h0000000, istat_q};
				end else if (paddr == `SDAC_REG_IMASK) begin
					prdata <= {28'h0000000, imask_q};
				end else if (isRes) begin
					prdata <= {8'h00, memRd};
				end else begin
					prdata <= 32'h0000_0000;
					pslverr <= 1'b1;
				end
			end
			if (devwrTake) begin
				devwrPend_q <= 1'b0;
			end
			if (wrHit && paddr == `SDAC_REG_CTRL) begin
				ctrl_q <= {16'h0000, pwdata[15:8], 2'b00, pwdata[5:0]};
			end
			// A second order while one is pending is refused, not queued
			if (wrHit && paddr == `SDAC_REG_DEVWR && !devwrPend_q) begin
				devwr_q <= pwdata[15:0];
				devwrPend_q <= 1'b1;
			end
			if (wrHit && paddr == `SDAC_REG_IMASK) begin
				imask_q <= pwdata[3:0];
			end
			// New events win over a write-one clear in the same cycle
			istat_q <= (istat_q & ~istatClr) | events;
			irqOut <= |(((istat_q & ~istatClr) | events) & imask_q);
		end
	end

endmodule

// *** sdac_ctrl_chk.sv ***
`timescale 1ns/1ns
`include "sdac_defines.vh"
module sdac_ctrl_chk #(
	parameter [15:0] WIN0_CYC = 16'd200,
	parameter [15:0] WIN1_CYC = 16'd400
) (
	// Clock and reset
	input wire core_clk,
	input wire rst_b,
	// APB
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire irqOut,
	// Converter port
	input wire [7:0] devAddr,
	input wire [7:0] devWdata,
	input wire devWr,
	input wire devRd,
	input wire [7:0] devRdata,
	input wire conversionEndIrq
);
	reg [7:0] modeQ;
	reg [7:0] offCntQ;
	wire modeWr = devWr && devAddr == `SDAC_DEV_MODE;
	wire cfgWr = devWr && devAddr != `SDAC_DEV_MODE && devAddr != `SDAC_DEV_CLR;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// ****************************************
	// Mirror of the converter mode register
	// ****************************************
	// Only a stop with power kept on starts the hold count; power-up is free
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			modeQ <= 8'h00;
			offCntQ <= 8'hff;
		end else begin
			if (modeWr)
				modeQ <= devWdata;
			if (modeWr && devWdata[7] && modeQ[3:0] != 4'h0 && devWdata[3:0] == 4'h0)
				offCntQ <= 8'h00;
			else if (offCntQ != 8'hff)
				offCntQ <= offCntQ + 8'h01;
		end
	end
	sequence s_access;
		psel && !penable ##1 psel && penable;
	endsequence
	sequence s_lo_rd;
		devRd && devAddr[4] && devAddr[1:0] == 2'd0;
	endsequence
	sequence s_mid_rd;
		devRd && devAddr[4] && devAddr[1:0] == 2'd1;
	endsequence
	a_apb_one_wait: assert property (s_access |-> !pready ##1 pready)
		else $error("APB answer not after exactly one wait state");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_slverr_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_dev_pulse: assert property (devRd |=> !(devWr || devRd))
		else $error("device strobe during a result read wait");
	a_dev_exclusive: assert property (!(devWr && devRd))
		else $error("device read and write strobes together");
	a_rate_power_off: assert property (
		modeWr && devWdata[6] != modeQ[6] |-> !modeQ[7] && !devWdata[7])
		else $error("rate changed while powered");
	a_ce_hold_time: assert property (
		modeWr && modeQ[7] && modeQ[3:0] == 4'h0 && devWdata[3:0] != 4'h0
		|-> offCntQ >= `SDAC_CE_HOLD_CYC)
		else $error("enable low too short before restart");
	a_cfg_stopped: assert property (cfgWr |-> modeQ[3:0] == 4'h0)
		else $error("configuration written while converting");
	a_read_enabled: assert property (devRd |-> modeQ[7] && modeQ[3:0] != 4'h0)
		else $error("result read while conversion disabled");
	a_byte_order: assert property (s_lo_rd |-> ##[6:20] s_mid_rd)
		else $error("middle byte not read after low byte");
endmodule

// *** sdac_dev_model.sv ***
`timescale 1ns/1ns
module sdac_dev_model #(
	parameter PERIOD = 40
) (
	// Clock and reset
	input wire core_clk,
	input wire rst_b,
	// Register port
	input wire [7:0] devAddr,
	input wire [7:0] devWdata,
	input wire devWr,
	input wire devRd,
	output logic [7:0] devRdata,
	output logic conversionEndIrq
);
	logic [7:0] regs [0:9];
	logic [7:0] clrLast;
	int tick;
	int convCnt;
	wire running = regs[0][7] && regs[0][3:0] != 4'h0;
	// Settling data is garbage, not zero, so a missed discard shows up
	function automatic logic [7:0] resByte(input logic [7:0] a);
		if (!regs[0][a[3:2]] || a[1:0] == 2'd3)
			return 8'h00;
		if (convCnt <= 80)
			return 8'hee;
		return {(a[1:0] == 2'd2) ? 4'ha : (a[1:0] == 2'd1) ? 4'h5 : 4'h1, 2'b00, a[3:2]};
	endfunction
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 10; i++)
				regs[i] <= 8'h00;
			clrLast <= 8'h00;
			tick <= 0;
			convCnt <= 0;
			conversionEndIrq <= 1'b0;
			devRdata <= 8'h00;
		end else begin
			conversionEndIrq <= 1'b0;
			if (!regs[0][7])
				convCnt <= 0;
			if (running) begin
				tick <= (tick == PERIOD - 1) ? 0 : tick + 1;
				if (tick == PERIOD - 1) begin
					conversionEndIrq <= 1'b1;
					convCnt <= convCnt + 1;
				end
			end
			if (devWr && devAddr < 8'h0a)
				regs[devAddr[3:0]] <= devWdata;
			if (devWr && devAddr == 8'h05)
				clrLast <= devWdata;
			if (devRd)
				devRdata <= devAddr[4] ? resByte(devAddr) : regs[devAddr[3:0]];
			else if (devWr)
				devRdata <= ~devRdata;
		end
	end
endmodule

// *** sdac_tb.sv ***
`timescale 1ns/1ns
module testbench;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire pready, pslverr, irqOut, devWr, devRd, conversionEndIrq;
	wire [7:0] devAddr, devWdata, devRdata;
	int error_cnt = 0;
	int cmp_count = 0;
	int irqCnt = 0;
	logic [31:0] rdv;
	logic err;
	always #5 core_clk = ~core_clk;
	always @(posedge conversionEndIrq)
		irqCnt++;
	sdac_ctrl #(.WIN0_CYC(16'd200), .WIN1_CYC(16'd400)) dut (.core_clk(core_clk),
		.rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irqOut(irqOut), .devAddr(devAddr), .devWdata(devWdata), .devWr(devWr),
		.devRd(devRd), .devRdata(devRdata), .conversionEndIrq(conversionEndIrq));
	sdac_dev_model #(.PERIOD(40)) dev (.core_clk(core_clk), .rst_b(rst_b),
		.devAddr(devAddr), .devWdata(devWdata), .devWr(devWr), .devRd(devRd),
		.devRdata(devRdata), .conversionEndIrq(conversionEndIrq));
	// ****************************************
	// Bus and compare helpers
	// ****************************************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_irq(input int lim);
		for (int i = 0; i < lim && irqOut !== 1'b1; i++)
			@(posedge core_clk);
		chk("irqOut", 1, irqOut);
	endtask
	task automatic dev_wr(input logic [15:0] v, input int gap);
		apb(8'h04, 1'b1, {16'h0, v});
		repeat (gap) @(posedge core_clk);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		apb(8'h00, 1'b0, 0);
		chk("ctrl", 0, rdv);
		apb(8'h08, 1'b0, 0);
		chk("status", 0, rdv);
		apb(8'h40, 1'b0, 0);
		chk("slverr rd", 1, err);
		apb(8'h40, 1'b1, 32'hffff_ffff);
		chk("slverr wr", 1, err);
	endtask
	task automatic t_power;
		apb(8'h10, 1'b1, 32'h8);
		apb(8'h00, 1'b1, 32'h5);
		wait_irq(5000);
		chk("discards", 80, irqCnt);
		chk("mode", 8'h81, dev.regs[0]);
		apb(8'h0c, 1'b1, 32'h8);
		repeat (2) @(posedge core_clk);
		chk("irq cleared", 0, irqOut);
	endtask
	task automatic t_result;
		apb(8'h10, 1'b1, 32'h1);
		apb(8'h0c, 1'b1, 32'h1);
		wait_irq(300);
		apb(8'h20, 1'b0, 0);
		chk("result0", 32'h00a0_5010, rdv);
		apb(8'h10, 1'b1, 32'h0);
		repeat (2) @(posedge core_clk);
		chk("irq masked", 0, irqOut);
		apb(8'h0c, 1'b0, 0);
		chk("istat done", 1, rdv[0]);
		chk("istat miss", 0, rdv[1]);
	endtask
	task automatic t_cfg;
		apb(8'h0c, 1'b1, 32'hf);
		dev_wr(16'h0133, 20);
		apb(8'h0c, 1'b0, 0);
		chk("refused", 1, rdv[2]);
		chk("gain kept", 0, dev.regs[1]);
		apb(8'h00, 1'b1, 32'h1);
		// A result read in flight delays the stop write
		for (int i = 0; i < 300 && dev.regs[0] !== 8'h80; i++)
			@(posedge core_clk);
		chk("stopped", 8'h80, dev.regs[0]);
		dev_wr(16'h0133, 20);
		chk("gain", 8'h33, dev.regs[1]);
	endtask
	task automatic t_latency;
		int n;
		apb(8'h0c, 1'b1, 32'h4);
		dev_wr(16'h0403, 20);
		chk("icr", 8'h03, dev.regs[4]);
		dev_wr(16'h0400, 400);
		chk("icr held", 8'h03, dev.regs[4]);
		apb(8'h0c, 1'b0, 0);
		chk("icr refused", 1, rdv[2]);
		dev_wr(16'h0501, 20);
		chk("clr", 8'h01, dev.clrLast);
		dev_wr(16'h0501, 20);
		chk("clr masked", 8'h00, dev.clrLast);
		apb(8'h00, 1'b1, 32'h5);
		n = irqCnt;
		for (int i = 0; i < 1000 && irqCnt < n + 4; i++)
			@(posedge core_clk);
		apb(8'h00, 1'b1, 32'h1);
		for (int i = 0; i < 300 && dev.regs[0] !== 8'h80; i++)
			@(posedge core_clk);
		apb(8'h00, 1'b1, 32'h5);
		repeat (100) @(posedge core_clk);
		chk("hold", 8'h80, dev.regs[0]);
		repeat (100) @(posedge core_clk);
		chk("restart", 8'h81, dev.regs[0]);
		apb(8'h00, 1'b1, 32'h1);
		for (int i = 0; i < 300 && dev.regs[0] !== 8'h80; i++)
			@(posedge core_clk);
		dev_wr(16'h0400, 20);
		chk("icr new", 8'h00, dev.regs[4]);
		dev_wr(16'h0501, 20);
		chk("clr again", 8'h01, dev.clrLast);
	endtask
	task automatic t_rate;
		apb(8'h00, 1'b1, 32'h3);
		repeat (30) @(posedge core_clk);
		chk("rate mode", 8'hc0, dev.regs[0]);
		apb(8'h08, 1'b0, 0);
		chk("rate status", 32'h3, {30'h0, rdv[1:0]});
		apb(8'h00, 1'b1, 32'h0);
		repeat (20) @(posedge core_clk);
		chk("power off", 8'h00, dev.regs[0]);
	endtask
	task automatic conclude;
		$display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		t_reset;
		t_power;
		t_result;
		t_cfg;
		t_latency;
		t_rate;
		conclude;
	end
	// Whole run needs well under 20000 cycles
	initial begin
		#400000;
		error_cnt++;
		conclude;
	end
endmodule
bind sdac_ctrl sdac_ctrl_chk #(.WIN0_CYC(WIN0_CYC), .WIN1_CYC(WIN1_CYC)) chk (
	.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.irqOut(irqOut), .devAddr(devAddr), .devWdata(devWdata), .devWr(devWr), .devRd(devRd),
	.devRdata(devRdata), .conversionEndIrq(conversionEndIrq));
